// ---- rtl/acsr_map.svh ----
// acsr_map.svh: register indices, field positions, reset values and timing
// counts of the converter control and status register block.
// assumes: included by bare name from acsr files; definitions only.
`ifndef ACSR_MAP_SVH
`define ACSR_MAP_SVH

// register indices; the apb byte address is four times the index
`define ACSR_IDX_CLKDIV   6'h05
`define ACSR_IDX_DRIVE    6'h06
`define ACSR_IDX_LVL_B    6'h07
`define ACSR_IDX_LVL_A    6'h08
`define ACSR_IDX_ROUTE    6'h09
`define ACSR_IDX_POL      6'h0c
`define ACSR_IDX_FLAGS    6'h0d
`define ACSR_IDX_MASK     6'h0e
`define ACSR_IDX_MODE_HI  6'h0f
`define ACSR_IDX_MODE_LO  6'h10
`define ACSR_IDX_UPD      6'h11

// field positions
`define ACSR_DIV_MSB      6
`define ACSR_DIV_LSB      4
`define ACSR_DRIVE_BIT    6
`define ACSR_LVL_MSB      5
`define ACSR_POLICY_MSB   4
`define ACSR_POLICY_LSB   3
`define ACSR_ROUTE_MSB    2
`define ACSR_POL_BIT      0
`define ACSR_HOLD_BIT     7
`define ACSR_MUTE_BIT     2
`define ACSR_EVT_VALID    8'h0b

// reset values
`define ACSR_RST_CLKDIV   3'h0
`define ACSR_RST_DRIVE    1'b1
`define ACSR_RST_CODE     6'h00
`define ACSR_RST_LEVEL    8'h00
`define ACSR_RST_POLICY   2'h3
`define ACSR_RST_ROUTE    3'h1
`define ACSR_RST_POL      1'b0
`define ACSR_POL_RSVD     8'hc0
`define ACSR_RST_EVT      8'h00

// timing and levels
`define ACSR_ZC_TIMEOUT   10'h200
`define ACSR_MUTE_LEVEL   8'ha0
`define ACSR_MIC_ROUTE    3'h0

`endif

// ---- rtl/acsr_pkg.sv ----
// acsr_pkg: types shared by the converter control and status register block.
// assumes: compiled before every acsr module.
package acsr_pkg;

   // apb request from the master and answer of the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } acsr_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } acsr_apb_rsp_type;

   // gain change policy
   typedef enum logic [1:0] {
      ACSR_CHG_IMM  = 2'b00,
      ACSR_CHG_ZC   = 2'b01,
      ACSR_CHG_RAMP = 2'b10,
      ACSR_CHG_BOTH = 2'b11
   } acsr_policy_type;

endpackage : acsr_pkg

// ---- rtl/acsr_event_capture.sv ----
// acsr_event_capture: sticky event flags with per-source mask and capture mode.
// assumes: conditions synchronous to ref_clk; clr names the bits just reported.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.svh"
module acsr_event_capture (
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic [7:0] cond,
   input  wire logic [7:0] mask,
   input  wire logic [7:0] mode_hi,
   input  wire logic [7:0] mode_lo,
   input  wire logic [7:0] clr,
   output logic      [7:0] flags
);
   import acsr_pkg::*;

   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] flags;
   } acsr_evt_state_type;

   acsr_evt_state_type s_r;
   acsr_evt_state_type s_nxt;
   logic [7:0]         hit;

   // edge or level detection per source, then sticky accumulate
   always_comb begin
      s_nxt = s_r;
      hit   = 8'h00;
      for (int i = 0; i < 8; i++) begin
         case ({mode_hi[i], mode_lo[i]})
            2'b00: hit[i] = cond[i] & ~s_r.prev[i];
            2'b01: hit[i] = ~cond[i] & s_r.prev[i];
            2'b10: hit[i] = cond[i];
            default: hit[i] = 1'b0;
         endcase
      end
      s_nxt.prev  = cond;
      // a new hit wins over the read clear; masked bits read zero
      s_nxt.flags = ((s_r.flags & ~clr) | hit) & mask & `ACSR_EVT_VALID;
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r.prev  <= 8'h00;
         s_r.flags <= `ACSR_RST_EVT;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign flags = s_r.flags;

endmodule : acsr_event_capture
`default_nettype wire

// ---- rtl/acsr_level_ramp.sv ----
// acsr_level_ramp: one channel's applied level in eighth-decibel units.
// assumes: frame_tick pulses once per sample period; zero_cross is a pulse.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.svh"
module acsr_level_ramp (
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   input  wire acsr_pkg::acsr_policy_type policy,
   input  wire logic [7:0]                target,
   input  wire logic                      frame_tick,
   input  wire logic                      zero_cross,
   output logic      [7:0]                level,
   output logic                           busy
);
   import acsr_pkg::*;

   typedef struct packed {
      logic [7:0] level;
      logic       due;
      logic [9:0] wait_cnt;
   } acsr_ramp_state_type;

   acsr_ramp_state_type s_r;
   acsr_ramp_state_type s_nxt;
   logic ramp_en;
   logic zc_en;
   logic pending;
   logic timed_out;
   logic apply_ok;

   assign ramp_en   = (policy == ACSR_CHG_RAMP) || (policy == ACSR_CHG_BOTH);
   assign zc_en     = (policy == ACSR_CHG_ZC) || (policy == ACSR_CHG_BOTH);
   assign pending   = s_r.level != target;
   // forced change on the 512th sample period without a crossing
   assign timed_out = frame_tick && (s_r.wait_cnt == `ACSR_ZC_TIMEOUT - 10'h001);
   assign apply_ok  = !zc_en || zero_cross || timed_out;

   // step or jump toward the target under the selected policy
   always_comb begin
      s_nxt = s_r;
      if (frame_tick) begin
         s_nxt.due = 1'b1;
      end
      if (zc_en && frame_tick) begin
         s_nxt.wait_cnt = s_r.wait_cnt + 10'h001;
      end
      if (!pending) begin
         s_nxt.due      = 1'b0;
         s_nxt.wait_cnt = 10'h000;
      end else if (ramp_en) begin
         // one eighth step per frame period, gated by crossing when enabled
         if (s_r.due && apply_ok) begin
            if ($signed(target) > $signed(s_r.level)) begin
               s_nxt.level = s_r.level + 8'h01;
            end else begin
               s_nxt.level = s_r.level - 8'h01;
            end
            s_nxt.due      = frame_tick;
            s_nxt.wait_cnt = 10'h000;
         end
      end else if (apply_ok) begin
         s_nxt.level    = target;
         s_nxt.wait_cnt = 10'h000;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r.level    <= `ACSR_RST_LEVEL;
         s_r.due      <= 1'b0;
         s_r.wait_cnt <= 10'h000;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.level;
   assign busy  = pending;

endmodule : acsr_level_ramp
`default_nettype wire

// ---- rtl/acsr_regs.sv ----
// acsr_regs: control and status registers of a stereo audio converter,
// reached over apb, with per-channel gain stepping and sticky event flags.
// assumes: all inputs synchronous to ref_clk; frame_clock is the sample-rate
// frame clock; zero_cross_a/b pulse at a signal crossing of each channel.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.svh"

// How it works
// - bits 6:4 select clock divide 1, 1.5, 2, 3, 4; upper codes reserved.
// - drive bit 6 low floats both amplifier outputs, high drives them.
// - six-bit level code is two's complement, half-decibel per step.
// - channel B level code at 07h, channel A at 08h, same coding.
// - ramp moves one eighth decibel per frame period, a decibel per eight.
// - ramp and crossing policies also govern mute-driven level changes.
// - crossing policy applies a change at the signal's zero crossing.
// - without a crossing the change is forced after 512 sample periods.
// - crossing detection and timeout are kept apart for each channel.
// - ramp plus crossing takes each eighth step at crossing or timeout.
// - policy bits 4:3: immediate, crossing, ramp, both; both at reset.
// - route 000 is microphone with boost, 001 to 110 line pairs.
// - polarity bit set gives push-pull high, clear gives open-drain low.
// - status bits accumulate since the last read; reading restarts them.
// - a masked status bit always reads zero.
// - status reads all zeros after reset.
// - status bit 3 clock fault, bit 1 overflow, bit 0 underflow.
// - mask bit one lets its source set status, zero blocks it.
// - mode high and low registers form a two-bit capture code.
// - capture code 00 arrival, 01 removal, 10 level, 11 none.
// - while hold is set, mute and level writes wait for its clearing.
module acsr_regs (
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   input  wire acsr_pkg::acsr_apb_req_type apb_req,
   output var  acsr_pkg::acsr_apb_rsp_type apb_rsp,
   input  wire logic                       frame_clock,
   input  wire logic                       zero_cross_a,
   input  wire logic                       zero_cross_b,
   input  wire logic                       clock_fault,
   input  wire logic                       overflow,
   input  wire logic                       underflow,
   output logic      [2:0]                 clock_divider_code,
   output logic                            amp_output_drive,
   output logic      [2:0]                 input_route,
   output logic                            mic_boost_enable,
   output logic      [7:0]                 level_a,
   output logic      [7:0]                 level_b,
   output logic                            mute_applied,
   output logic                            irq_out,
   output logic                            irq_oe
);
   import acsr_pkg::*;

   typedef struct packed {
      logic [2:0]      div;
      logic            drive;
      logic [5:0]      code_b;
      logic [5:0]      code_a;
      acsr_policy_type policy;
      logic [2:0]      route;
      logic            mic;
      logic            pol;
      logic [7:0]      mask;
      logic [7:0]      mode_hi;
      logic [7:0]      mode_lo;
      logic            hold;
      logic            mute;
      logic [5:0]      eff_a;
      logic [5:0]      eff_b;
      logic            eff_mute;
      logic            frame_q;
      logic            irq_o;
      logic            irq_en;
      logic [31:0]     rdata;
      logic            err;
   } acsr_regs_state_type;

   acsr_regs_state_type s_r;
   acsr_regs_state_type s_nxt;

   logic [5:0] idx;
   logic       mapped;
   logic       setup;
   logic       access;
   logic       frame_tick;
   logic [7:0] flags;
   logic [7:0] flag_clr;
   logic [7:0] cond;
   logic [7:0] rd_byte;
   logic [1:0] busy;
   logic [7:0] target_a;
   logic [7:0] target_b;

   // mapped register indices; anything else answers with an error
   function automatic logic acsr_is_mapped(input logic [5:0] i);
      acsr_is_mapped = (i == `ACSR_IDX_CLKDIV)  || (i == `ACSR_IDX_DRIVE)   ||
                       (i == `ACSR_IDX_LVL_B)   || (i == `ACSR_IDX_LVL_A)   ||
                       (i == `ACSR_IDX_ROUTE)   || (i == `ACSR_IDX_POL)     ||
                       (i == `ACSR_IDX_FLAGS)   || (i == `ACSR_IDX_MASK)    ||
                       (i == `ACSR_IDX_MODE_HI) || (i == `ACSR_IDX_MODE_LO) ||
                       (i == `ACSR_IDX_UPD);
   endfunction : acsr_is_mapped

   // applied level in eighth decibels; mute pulls the level to ACSR_MUTE_LEVEL, a0h
   function automatic logic [7:0] acsr_lvl_target(input logic [5:0] code,
                                                  input logic       mute);
      if (mute) begin
         acsr_lvl_target = `ACSR_MUTE_LEVEL;
      end else begin
         acsr_lvl_target = {code, 2'b00};
      end
   endfunction : acsr_lvl_target

   // apb phase and address decode
   assign idx        = apb_req.paddr[7:2];
   assign mapped     = (apb_req.paddr[1:0] == 2'b00) && acsr_is_mapped(idx);
   assign setup      = apb_req.psel && !apb_req.penable;
   assign access     = apb_req.psel && apb_req.penable;
   assign frame_tick = frame_clock && !s_r.frame_q;

   // status read clears only the bits captured in the setup phase
   always_comb begin
      flag_clr = 8'h00;
      if (access && !apb_req.pwrite && !s_r.err && (idx == `ACSR_IDX_FLAGS)) begin
         flag_clr = s_r.rdata[7:0];
      end
   end

   // condition vector at the status bit positions
   always_comb begin
      cond    = 8'h00;
      cond[3] = clock_fault;
      cond[1] = overflow;
      cond[0] = underflow;
   end

   // read multiplexer; reserved bits read zero except polarity bits 7:6
   always_comb begin
      rd_byte = 8'h00;
      if (idx == `ACSR_IDX_CLKDIV) begin
         rd_byte[`ACSR_DIV_MSB:`ACSR_DIV_LSB] = s_r.div;
      end else if (idx == `ACSR_IDX_DRIVE) begin
         rd_byte[`ACSR_DRIVE_BIT] = s_r.drive;
      end else if (idx == `ACSR_IDX_LVL_B) begin
         rd_byte[`ACSR_LVL_MSB:0] = s_r.code_b;
      end else if (idx == `ACSR_IDX_LVL_A) begin
         rd_byte[`ACSR_LVL_MSB:0] = s_r.code_a;
      end else if (idx == `ACSR_IDX_ROUTE) begin
         rd_byte[`ACSR_POLICY_MSB:`ACSR_POLICY_LSB] = s_r.policy;
         rd_byte[`ACSR_ROUTE_MSB:0] = s_r.route;
      end else if (idx == `ACSR_IDX_POL) begin
         rd_byte = `ACSR_POL_RSVD;
         rd_byte[`ACSR_POL_BIT] = s_r.pol;
      end else if (idx == `ACSR_IDX_FLAGS) begin
         rd_byte = flags;
      end else if (idx == `ACSR_IDX_MASK) begin
         rd_byte = s_r.mask & `ACSR_EVT_VALID;
      end else if (idx == `ACSR_IDX_MODE_HI) begin
         rd_byte = s_r.mode_hi & `ACSR_EVT_VALID;
      end else if (idx == `ACSR_IDX_MODE_LO) begin
         rd_byte = s_r.mode_lo & `ACSR_EVT_VALID;
      end else if (idx == `ACSR_IDX_UPD) begin
         rd_byte[`ACSR_HOLD_BIT] = s_r.hold;
         rd_byte[`ACSR_MUTE_BIT] = s_r.mute;
         rd_byte[1:0] = busy;
      end
   end

   // next state: apb capture and writes, held update, interrupt pin
   always_comb begin
      s_nxt = s_r;
      s_nxt.frame_q = frame_clock;
      // read data and error are settled in the setup phase
      if (setup) begin
         s_nxt.err   = !mapped;
         s_nxt.rdata = {24'h000000, rd_byte};
      end
      if (access && apb_req.pwrite && mapped) begin
         if (idx == `ACSR_IDX_CLKDIV) begin
            s_nxt.div = apb_req.pwdata[`ACSR_DIV_MSB:`ACSR_DIV_LSB];
         end else if (idx == `ACSR_IDX_DRIVE) begin
            s_nxt.drive = apb_req.pwdata[`ACSR_DRIVE_BIT];
         end else if (idx == `ACSR_IDX_LVL_B) begin
            s_nxt.code_b = apb_req.pwdata[`ACSR_LVL_MSB:0];
         end else if (idx == `ACSR_IDX_LVL_A) begin
            s_nxt.code_a = apb_req.pwdata[`ACSR_LVL_MSB:0];
         end else if (idx == `ACSR_IDX_ROUTE) begin
            s_nxt.policy = acsr_policy_type'(
               apb_req.pwdata[`ACSR_POLICY_MSB:`ACSR_POLICY_LSB]);
            s_nxt.route = apb_req.pwdata[`ACSR_ROUTE_MSB:0];
         end else if (idx == `ACSR_IDX_POL) begin
            s_nxt.pol = apb_req.pwdata[`ACSR_POL_BIT];
         end else if (idx == `ACSR_IDX_MASK) begin
            s_nxt.mask = apb_req.pwdata[7:0] & `ACSR_EVT_VALID;
         end else if (idx == `ACSR_IDX_MODE_HI) begin
            s_nxt.mode_hi = apb_req.pwdata[7:0] & `ACSR_EVT_VALID;
         end else if (idx == `ACSR_IDX_MODE_LO) begin
            s_nxt.mode_lo = apb_req.pwdata[7:0] & `ACSR_EVT_VALID;
         end else if (idx == `ACSR_IDX_UPD) begin
            s_nxt.hold = apb_req.pwdata[`ACSR_HOLD_BIT];
            s_nxt.mute = apb_req.pwdata[`ACSR_MUTE_BIT];
         end
      end
      // microphone boost follows the route code
      s_nxt.mic = (s_nxt.route == `ACSR_MIC_ROUTE);
      // stored codes reach the ramps only while hold is clear
      if (!s_r.hold) begin
         s_nxt.eff_a    = s_r.code_a;
         s_nxt.eff_b    = s_r.code_b;
         s_nxt.eff_mute = s_r.mute;
      end
      // push-pull active high, or open-drain pulled low when asserted
      if (s_r.pol) begin
         s_nxt.irq_o  = |flags;
         s_nxt.irq_en = 1'b1;
      end else begin
         s_nxt.irq_o  = 1'b0;
         s_nxt.irq_en = |flags;
      end
   end

   // state register with documented reset values
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r          <= '0;
         s_r.div      <= `ACSR_RST_CLKDIV;
         s_r.drive    <= `ACSR_RST_DRIVE;
         s_r.code_a   <= `ACSR_RST_CODE;
         s_r.code_b   <= `ACSR_RST_CODE;
         s_r.eff_a    <= `ACSR_RST_CODE;
         s_r.eff_b    <= `ACSR_RST_CODE;
         s_r.policy   <= acsr_policy_type'(`ACSR_RST_POLICY);
         s_r.route    <= `ACSR_RST_ROUTE;
         s_r.pol      <= `ACSR_RST_POL;
      end else begin
         s_r <= s_nxt;
      end
   end

   // sticky event flags with mask and capture mode
   acsr_event_capture u_events (
      .ref_clk (ref_clk),
      .srst    (srst),
      .cond    (cond),
      .mask    (s_r.mask),
      .mode_hi (s_r.mode_hi),
      .mode_lo (s_r.mode_lo),
      .clr     (flag_clr),
      .flags   (flags)
   );

   // level targets include mute, so both share the change policy
   assign target_a = acsr_lvl_target(s_r.eff_a, s_r.eff_mute);
   assign target_b = acsr_lvl_target(s_r.eff_b, s_r.eff_mute);

   // independent stepping and crossing timeout per channel
   acsr_level_ramp u_ramp_a (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .policy     (s_r.policy),
      .target     (target_a),
      .frame_tick (frame_tick),
      .zero_cross (zero_cross_a),
      .level      (level_a),
      .busy       (busy[1])
   );

   acsr_level_ramp u_ramp_b (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .policy     (s_r.policy),
      .target     (target_b),
      .frame_tick (frame_tick),
      .zero_cross (zero_cross_b),
      .level      (level_b),
      .busy       (busy[0])
   );

   // register-driven outputs
   assign clock_divider_code = s_r.div;
   assign amp_output_drive   = s_r.drive;
   assign input_route        = s_r.route;
   assign mic_boost_enable   = s_r.mic;
   assign mute_applied       = s_r.eff_mute;
   assign irq_out            = s_r.irq_o;
   assign irq_oe             = s_r.irq_en;

   // zero-wait slave: every access phase completes at once
   assign apb_rsp.prdata  = s_r.rdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = s_r.err;

endmodule : acsr_regs
`default_nettype wire

// ---- dv/acsr_regs_checker.sv ----
// acsr_regs_checker: port assertions for the converter register block.
// assumes: bound into acsr_regs; one ref_clk domain, srst synchronous.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.svh"
module acsr_regs_checker (
   input wire logic                       ref_clk,
   input wire logic                       srst,
   input wire acsr_pkg::acsr_apb_req_type apb_req,
   input wire acsr_pkg::acsr_apb_rsp_type apb_rsp,
   input wire logic [2:0]                 clock_divider_code,
   input wire logic                       amp_output_drive,
   input wire logic [2:0]                 input_route,
   input wire logic                       mic_boost_enable,
   input wire logic [7:0]                 level_a,
   input wire logic                       irq_out,
   input wire logic                       irq_oe
);
   import acsr_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic acc;
   logic wr;
   // access phase and write strobe
   assign acc = apb_req.psel && apb_req.penable;
   assign wr  = acc && apb_req.pwrite;
   property p_div;
      wr && apb_req.paddr == {`ACSR_IDX_CLKDIV, 2'b00}
      |=> clock_divider_code == $past(apb_req.pwdata[6:4]);
   endproperty
   a_div: assert property (p_div) else $error("divider code not taken");
   property p_drive;
      wr && apb_req.paddr == {`ACSR_IDX_DRIVE, 2'b00}
      |=> amp_output_drive == $past(apb_req.pwdata[6]);
   endproperty
   a_drive: assert property (p_drive) else $error("drive bit not taken");
   property p_route;
      wr && apb_req.paddr == {`ACSR_IDX_ROUTE, 2'b00} |=> input_route == $past(apb_req.pwdata[2:0]);
   endproperty
   a_route: assert property (p_route) else $error("route not taken");
   property p_mic;
      mic_boost_enable == (input_route == 3'h0);
   endproperty
   a_mic: assert property (p_mic) else $error("boost differs from route");
   property p_irq;
      irq_out |-> irq_oe;
   endproperty
   a_irq: assert property (p_irq) else $error("irq high while undriven");
   property p_misal;
      acc && apb_req.paddr[1:0] != 2'b00 |-> apb_rsp.pslverr;
   endproperty
   a_misal: assert property (p_misal) else $error("misaligned access accepted");
   property p_unmap;
      acc && apb_req.paddr == 8'h28 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
   property p_ready;
      acc |-> apb_rsp.pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_rst;
      $fell(srst) |-> level_a == 8'h00 && !irq_oe && apb_rsp.prdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   c_div: cover property (wr && apb_req.paddr == {`ACSR_IDX_CLKDIV, 2'b00});
   c_irq: cover property (irq_out && irq_oe);
   c_err: cover property (acc && apb_rsp.pslverr);
endmodule : acsr_regs_checker
bind acsr_regs acsr_regs_checker acsr_regs_checker_i (
   .ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .clock_divider_code(clock_divider_code), .amp_output_drive(amp_output_drive),
   .input_route(input_route), .mic_boost_enable(mic_boost_enable),
   .level_a(level_a), .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire

// ---- dv/acsr_regs_tb.sv ----
// acsr_regs_tb: self-checking bench for the converter register block.
// assumes: acsr_pkg compiled first; checker bound separately.
`timescale 1ns/100ps
`default_nettype none
`include "acsr_map.svh"
module acsr_regs_tb;
   import acsr_pkg::*;
   typedef struct packed {
      logic [5:0] idx;
      logic [7:0] wd;
      logic [7:0] rexp;
   } acsr_row_type;
   logic             ref_clk, srst, frame_clock, zero_cross_a, zero_cross_b;
   logic             clock_fault, overflow, underflow, err;
   acsr_apb_req_type req;
   acsr_apb_rsp_type rsp;
   logic [2:0]       clock_divider_code, input_route;
   logic             amp_output_drive, mic_boost_enable, mute_applied, irq_out, irq_oe;
   logic [7:0]       level_a, level_b;
   logic [31:0]      rd;
   int               miscompares, checks;
   acsr_row_type     rows [9] = '{
      '{`ACSR_IDX_ROUTE, 8'h02, 8'h02}, '{`ACSR_IDX_CLKDIV, 8'h40, 8'h40},
      '{`ACSR_IDX_DRIVE, 8'h00, 8'h00}, '{`ACSR_IDX_LVL_B, 8'h28, 8'h28},
      '{`ACSR_IDX_LVL_A, 8'h18, 8'h18}, '{`ACSR_IDX_POL, 8'h01, 8'hc1},
      '{`ACSR_IDX_MASK, 8'h0b, 8'h0b}, '{`ACSR_IDX_MODE_HI, 8'h00, 8'h00},
      '{`ACSR_IDX_MODE_LO, 8'h00, 8'h00}};

   acsr_regs acsr_regs_i (
      .ref_clk(ref_clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
      .frame_clock(frame_clock), .zero_cross_a(zero_cross_a), .zero_cross_b(zero_cross_b),
      .clock_fault(clock_fault), .overflow(overflow), .underflow(underflow),
      .clock_divider_code(clock_divider_code), .amp_output_drive(amp_output_drive),
      .input_route(input_route), .mic_boost_enable(mic_boost_enable), .level_a(level_a),
      .level_b(level_b), .mute_applied(mute_applied), .irq_out(irq_out), .irq_oe(irq_oe));

   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task give_verdict;
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, w, a, {24'h0, wd}};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      for (int n = 0; n <= 16; n++) begin
         @(posedge ref_clk);
         if (rsp.pready === 1'b1) break;
         if (n == 16) begin
            miscompares++;
            give_verdict();
         end
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask : apb

   task wr(input logic [5:0] idx, input logic [7:0] wd);
      apb(1'b1, {idx, 2'b00}, wd);
   endtask : wr

   task rchk(input logic [5:0] idx, input logic [7:0] e);
      apb(1'b0, {idx, 2'b00}, 8'h00);
      chk("prdata", {24'h0, e}, rd);
   endtask : rchk

   // one frame period: a rising frame_clock edge
   task tick;
      frame_clock <= 1'b1;
      repeat (2) @(posedge ref_clk);
      frame_clock <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : tick

   task pulse_ovf;
      overflow <= 1'b1;
      repeat (2) @(posedge ref_clk);
      overflow <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : pulse_ovf

   // main sequence
   initial begin
      {srst, req, frame_clock, zero_cross_a, zero_cross_b} = '0;
      {clock_fault, overflow, underflow} = 3'h0;
      srst = 1'b1;
      miscompares = 0;
      checks = 0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      rchk(`ACSR_IDX_FLAGS, 8'h00);
      rchk(`ACSR_IDX_ROUTE, 8'h19);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         rchk(rows[i].idx, rows[i].rexp);
      end
      for (int c = 0; c < 7; c++) begin
         wr(`ACSR_IDX_ROUTE, {5'h00, c[2:0]});
         if (c < 5) wr(`ACSR_IDX_CLKDIV, {1'b0, c[2:0], 4'h0});
         @(posedge ref_clk);
         chk("route", c, input_route);
         chk("boost", c == 0, mic_boost_enable);
         if (c < 5) chk("div", c, clock_divider_code);
      end
      chk("level_a", 8'h60, level_a);
      chk("level_b", 8'ha0, level_b);
      chk("drive", 1'b0, amp_output_drive);
      wr(`ACSR_IDX_DRIVE, 8'h40);
      @(posedge ref_clk);
      chk("drive", 1'b1, amp_output_drive);
      // stepped ramp: eight frame periods give one decibel
      wr(`ACSR_IDX_ROUTE, 8'h10);
      wr(`ACSR_IDX_LVL_A, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk("level_a", 8'h60, level_a);
      repeat (8) tick();
      chk("level_a", 8'h58, level_a);
      wr(`ACSR_IDX_LVL_A, 8'h16);
      // zero crossing per channel, then timeout
      wr(`ACSR_IDX_ROUTE, 8'h08);
      wr(`ACSR_IDX_LVL_A, 8'h00);
      zero_cross_b <= 1'b1;
      @(posedge ref_clk);
      zero_cross_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("level_a", 8'h58, level_a);
      zero_cross_a <= 1'b1;
      @(posedge ref_clk);
      zero_cross_a <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("level_a", 8'h00, level_a);
      wr(`ACSR_IDX_LVL_B, 8'h00);
      repeat (511) tick();
      chk("level_b", 8'ha0, level_b);
      repeat (513) tick();
      chk("level_b", 8'h00, level_b);
      // rising capture, read clears, interrupt follows
      pulse_ovf();
      chk("irq_out", 1'b1, irq_out);
      chk("irq_oe", 1'b1, irq_oe);
      rchk(`ACSR_IDX_FLAGS, 8'h02);
      rchk(`ACSR_IDX_FLAGS, 8'h00);
      repeat (3) @(posedge ref_clk);
      chk("irq_out", 1'b0, irq_out);
      // falling capture on clock fault
      wr(`ACSR_IDX_MODE_LO, 8'h08);
      clock_fault <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rchk(`ACSR_IDX_FLAGS, 8'h00);
      clock_fault <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rchk(`ACSR_IDX_FLAGS, 8'h08);
      // level capture on underflow, then masked
      wr(`ACSR_IDX_MODE_HI, 8'h01);
      underflow <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rchk(`ACSR_IDX_FLAGS, 8'h01);
      rchk(`ACSR_IDX_FLAGS, 8'h01);
      wr(`ACSR_IDX_MASK, 8'h00);
      rchk(`ACSR_IDX_FLAGS, 8'h00);
      underflow <= 1'b0;
      // open-drain interrupt drives low only
      wr(`ACSR_IDX_POL, 8'h00);
      wr(`ACSR_IDX_MASK, 8'h02);
      wr(`ACSR_IDX_MODE_HI, 8'h00);
      pulse_ovf();
      chk("irq_out", 1'b0, irq_out);
      chk("irq_oe", 1'b1, irq_oe);
      rchk(`ACSR_IDX_FLAGS, 8'h02);
      // unmapped and misaligned accesses are refused
      apb(1'b0, 8'h28, 8'h00);
      chk("pslverr", 1'b1, err);
      chk("prdata", 32'h0, rd);
      apb(1'b1, 8'h15, 8'hff);
      chk("pslverr", 1'b1, err);
      rchk(`ACSR_IDX_CLKDIV, 8'h40);
      // held mute, gated ramp step
      wr(`ACSR_IDX_UPD, 8'h84);
      wr(`ACSR_IDX_ROUTE, 8'h18);
      chk("mute", 1'b0, mute_applied);
      wr(`ACSR_IDX_UPD, 8'h04);
      repeat (2) tick();
      chk("mute", 1'b1, mute_applied);
      chk("level_a", 8'h00, level_a);
      zero_cross_a <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("level_a", 8'hff, level_a);
      give_verdict();
   end
endmodule : acsr_regs_tb
`default_nettype wire
